// File: logic/psol_pkg.sv
// Constants, register map and carriers of the pressure switch logic
package psol_pkg;
    // Pressure counts: 1 count = 0.01 % of measuring range
    localparam logic [15:0] RANGE_FULL = 16'h2710;
    localparam logic [15:0] MIN_HYST = 16'h0019;
    localparam logic [15:0] ZERO_MAX = 16'h012C;
    localparam logic [15:0] REL_DEF = 16'h2328;
    localparam logic [15:0] DELAY_MAX = 16'h1964;
    localparam logic [15:0] DAMP_MAX = 16'h1964;
    localparam logic [15:0] DAMP_DEF = 16'h0000;
    localparam logic [15:0] MIN_RST = 16'hFFFF;
    localparam logic [15:0] CODE_DEF = 16'h0000;
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_TIME_MS = 10;
    localparam int unsigned TICK_CYC = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // Refresh periods in 10 ms ticks for 1, 2, 5, 10 updates per second
    localparam logic [6:0] REF_P1 = 7'h64;
    localparam logic [6:0] REF_P2 = 7'h32;
    localparam logic [6:0] REF_P5 = 7'h14;
    localparam logic [6:0] REF_P10 = 7'h0A;
    localparam int unsigned TAG_LEN = 32;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_DASH = 8'h2D;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SP1 = 8'h04;
    localparam logic [7:0] A_RP1 = 8'h08;
    localparam logic [7:0] A_SP2 = 8'h0C;
    localparam logic [7:0] A_RP2 = 8'h10;
    localparam logic [7:0] A_DS1 = 8'h14;
    localparam logic [7:0] A_DR1 = 8'h18;
    localparam logic [7:0] A_DS2 = 8'h1C;
    localparam logic [7:0] A_DR2 = 8'h20;
    localparam logic [7:0] A_DMP1 = 8'h24;
    localparam logic [7:0] A_DMP2 = 8'h28;
    localparam logic [7:0] A_DMP3 = 8'h2C;
    localparam logic [7:0] A_CMD = 8'h30;
    localparam logic [7:0] A_CODE = 8'h34;
    localparam logic [7:0] A_DIGIT = 8'h38;
    localparam logic [7:0] A_STAT = 8'h3C;
    localparam logic [7:0] A_MIN = 8'h40;
    localparam logic [7:0] A_MAX = 8'h44;
    localparam logic [7:0] A_LIVE = 8'h48;
    localparam logic [7:0] A_ZERO = 8'h4C;
    localparam logic [7:0] A_TIDX = 8'h50;
    localparam logic [7:0] A_TDAT = 8'h54;
    localparam logic [7:0] A_TLEN = 8'h58;
    // Command and status bit positions
    localparam int unsigned CMD_ZERO = 0;
    localparam int unsigned CMD_MMCLR = 1;
    localparam int unsigned CMD_LOCK = 2;
    localparam int unsigned ST_UNLK = 0;
    localparam int unsigned ST_ZERR = 1;
    localparam int unsigned ST_CLIP = 2;

    typedef enum logic [1:0] {
        HYST_NORM_OPEN = 2'h0, HYST_NORM_CLOSED = 2'h1,
        WINDOW_NORM_OPEN = 2'h2, WINDOW_NORM_CLOSED = 2'h3
    } psol_mode_e;
    typedef enum logic [2:0] {
        SEL_LIVE = 3'h0, SEL_MIN = 3'h1, SEL_MAX = 3'h2, SEL_OFF = 3'h3,
        SEL_SP1 = 3'h4, SEL_RP1 = 3'h5, SEL_SP2 = 3'h6, SEL_RP2 = 3'h7
    } psol_sel_e;
    typedef enum logic [1:0] {
        RATE_1 = 2'h0, RATE_2 = 2'h1, RATE_5 = 2'h2, RATE_10 = 2'h3
    } psol_rate_e;
    typedef enum logic [2:0] {
        U_BAR = 3'h0, U_MBAR = 3'h1, U_MPA = 3'h2, U_KPA = 3'h3,
        U_PSI = 3'h4, U_KGCM = 3'h5, U_PCT = 3'h6
    } psol_unit_e;
    typedef enum logic [1:0] {
        SW_IDLE = 2'b01, SW_ACTIVE = 2'b10
    } psol_sw_e;

    typedef struct packed {
        psol_unit_e unit;
        logic rotate;
        logic full_res;
        psol_rate_e rate;
        psol_sel_e sel;
        psol_mode_e mode2;
        psol_mode_e mode1;
    } psol_ctrl_s;
    localparam psol_ctrl_s CTRL_DEF = '{U_BAR, 1'b0, 1'b0, RATE_5,
        SEL_LIVE, HYST_NORM_OPEN, HYST_NORM_OPEN};

    typedef struct packed {
        logic valid;
        logic [15:0] value;
    } psol_press_s;
    typedef struct packed {
        logic update;
        logic blank;
        logic rotate;
        logic full_res;
        psol_unit_e unit;
        logic [15:0] value;
    } psol_ind_s;
endpackage : psol_pkg

// File: logic/psol_top.sv
// Pressure switch decision logic with APB register file
//
// What this block does
// - Hysteresis: switch on reaching switch point
// - Hysteresis: hold until release point reached
// - Window: on while inside window limits
// - Window: off while outside window limits
// - Change only after switch delay elapsed
// - Interrupted condition keeps state, restarts delay
// - Release after uninterrupted release delay
// - Per-output damping, zero to 65 s
// - Separate analog damping, zero to 65 s
// - Zero adjust captures reading, max 3 %
// - Indicator selects live, min, max, off, thresholds
// - Refresh 1, 2, 5, 10 per second
// - Track min and max, clear on command
// - Four digit code, 0000 means none
// - 32 char name, double space ends entry
// - Rounded resolution default, or full resolution
// - Rotate indicator by 180 degrees
// - Selectable unit with value conversion
// - Per-output hysteresis/window, open/closed, default hysteresis open
// - Release point at least 0.25 % below
`timescale 1ns/1ps
`default_nettype none
module psol_top
    import psol_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter logic [6:0][15:0] UNIT_SCALE = {7{16'h1000}}
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire psol_press_s press_in,
    output logic [1:0] switch_out,
    output logic [15:0] analog_value,
    output psol_ind_s indicator
);

////////////////////////////////////////////////////////////////////////////////
// Reset release and tick

logic [1:0] rst_sync_q;
logic rst_n;
always_ff @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
        rst_sync_q <= 2'b00;
    else
        rst_sync_q <= {rst_sync_q[0], 1'b1};
end
assign rst_n = rst_sync_q[1];

logic [31:0] tick_cnt_q;
logic tick;
assign tick = (tick_cnt_q == TICK_CYCLES - 1);
always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
        tick_cnt_q <= 32'h00000000;
    else
        tick_cnt_q <= tick ? 32'h00000000 : tick_cnt_q + 32'h00000001;
end

////////////////////////////////////////////////////////////////////////////////
// APB decode

psol_ctrl_s ctrl_q;
logic [3:0][15:0] thr_q;  // sp1, rp1, sp2, rp2
logic [3:0][15:0] dly_q;  // ds1, dr1, ds2, dr2
logic [2:0][15:0] damp_q;
logic [15:0] code_q, entry_q, zero_q, min_q, max_q;
logic [2:0] ndig_q;
logic unlocked_q, zerr_q, clip_q, ready_q;
logic [4:0] tidx_q;
logic [5:0] tlen_q;
logic [7:0] tag_mem [TAG_LEN];
logic [15:0] live;

logic access, wr, cfg_ok, wr_cfg, bad_addr, bad_val, unlocked;
logic wr_ctrl, wr_cmd, wr_code, wr_digit, wr_stat, wr_tidx, wr_tdat;
logic [3:0] wr_thr, wr_dly;
logic [2:0] wr_damp;
logic [15:0] wval;
logic [7:0] tch;
logic tch_ok, tch_space, prev_space;
logic [31:0] rdata;

assign access = psel & penable;
assign pready = access & ready_q;
assign wval = pwdata[15:0];
assign tch = pwdata[7:0];
assign unlocked = (code_q == CODE_DEF) | unlocked_q;
assign cfg_ok = unlocked;
assign tch_ok = (tch >= 8'h41 && tch <= 8'h5A) ||
    (tch >= 8'h30 && tch <= 8'h39) || tch == CH_DASH || tch == CH_SPACE;
assign tch_space = (tch == CH_SPACE);
assign prev_space = (tidx_q != 5'h00) &&
    (tag_mem[tidx_q - 5'h01] == CH_SPACE);

assign bad_addr = (paddr[1:0] != 2'b00) || (paddr > A_TLEN);
// Locked writes and illegal values are refused with an error
assign bad_val = pwrite && (
    (!cfg_ok && paddr != A_DIGIT && paddr != A_STAT) ||
    ((paddr == A_DS1 || paddr == A_DR1 || paddr == A_DS2 ||
      paddr == A_DR2) && wval > DELAY_MAX) ||
    ((paddr == A_DMP1 || paddr == A_DMP2 || paddr == A_DMP3) &&
      wval > DAMP_MAX) ||
    ((paddr == A_SP1 || paddr == A_SP2) &&
      (wval < MIN_HYST || wval > RANGE_FULL)) ||
    (paddr == A_DIGIT && pwdata[3:0] > 4'h9) ||
    (paddr == A_TDAT && !tch_ok));
assign pslverr = pready & (bad_addr | bad_val);
assign wr = pready & pwrite & ~bad_addr & ~bad_val;
assign wr_cfg = wr & cfg_ok;
assign wr_ctrl = wr_cfg & (paddr == A_CTRL);
assign wr_cmd = wr_cfg & (paddr == A_CMD);
assign wr_code = wr_cfg & (paddr == A_CODE);
assign wr_digit = wr & (paddr == A_DIGIT);
assign wr_stat = wr & (paddr == A_STAT);
assign wr_tidx = wr_cfg & (paddr == A_TIDX);
assign wr_tdat = wr_cfg & (paddr == A_TDAT);

genvar gi;
generate
    for (gi = 0; gi < 4; gi++)
    begin : g_wr
        assign wr_thr[gi] = wr_cfg & (paddr == A_SP1 + 8'(gi * 4));
        assign wr_dly[gi] = wr_cfg & (paddr == A_DS1 + 8'(gi * 4));
    end
    for (gi = 0; gi < 3; gi++)
    begin : g_wd
        assign wr_damp[gi] = wr_cfg & (paddr == A_DMP1 + 8'(gi * 4));
    end
endgenerate

always_comb
begin
    rdata = 32'h00000000;
    case (paddr)
        A_CTRL: rdata = 32'(ctrl_q);
        A_SP1: rdata = {16'h0000, thr_q[0]};
        A_RP1: rdata = {16'h0000, thr_q[1]};
        A_SP2: rdata = {16'h0000, thr_q[2]};
        A_RP2: rdata = {16'h0000, thr_q[3]};
        A_DS1: rdata = {16'h0000, dly_q[0]};
        A_DR1: rdata = {16'h0000, dly_q[1]};
        A_DS2: rdata = {16'h0000, dly_q[2]};
        A_DR2: rdata = {16'h0000, dly_q[3]};
        A_DMP1: rdata = {16'h0000, damp_q[0]};
        A_DMP2: rdata = {16'h0000, damp_q[1]};
        A_DMP3: rdata = {16'h0000, damp_q[2]};
        A_STAT: rdata = {27'h0000000, switch_out, clip_q, zerr_q, unlocked};
        A_MIN: rdata = {16'h0000, min_q};
        A_MAX: rdata = {16'h0000, max_q};
        A_LIVE: rdata = {16'h0000, live};
        A_ZERO: rdata = {16'h0000, zero_q};
        A_TIDX: rdata = {27'h0000000, tidx_q};
        A_TDAT: rdata = ({1'b0, tidx_q} < tlen_q) ?
            {24'h000000, tag_mem[tidx_q]} : 32'h00000000;
        A_TLEN: rdata = {26'h0000000, tlen_q};
        default: rdata = 32'h00000000;
    endcase
end

// One wait state so that read data comes from a flip-flop
always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ready_q <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        ready_q <= access & ~ready_q;
        prdata <= (access & ~ready_q & ~pwrite) ? rdata : prdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration registers

logic [15:0] sp_min_gap [2];
logic [1:0] clip_set;
generate
    for (gi = 0; gi < 2; gi++)
    begin : g_thr
        // keep release point below switch point
        assign sp_min_gap[gi] = (wr_thr[2 * gi] ? wval : thr_q[2 * gi])
            - MIN_HYST;
        assign clip_set[gi] = wr_thr[2 * gi] && thr_q[2 * gi + 1] >
            wval - MIN_HYST;
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                thr_q[2 * gi] <= RANGE_FULL;
                thr_q[2 * gi + 1] <= REL_DEF;
            end
            else
            begin
                if (wr_thr[2 * gi])
                    thr_q[2 * gi] <= wval;
                if (wr_thr[2 * gi + 1])
                    thr_q[2 * gi + 1] <= (wval > sp_min_gap[gi]) ?
                        sp_min_gap[gi] : wval;
                else if (clip_set[gi])
                    thr_q[2 * gi + 1] <= sp_min_gap[gi];
            end
        end
    end
endgenerate

always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ctrl_q <= CTRL_DEF;
        dly_q <= '0;
        damp_q <= {3{DAMP_DEF}};
        code_q <= CODE_DEF;
    end
    else
    begin
        if (wr_ctrl)
            ctrl_q <= psol_ctrl_s'(pwdata[$bits(psol_ctrl_s)-1:0]);
        for (int i = 0; i < 4; i++)
            if (wr_dly[i])
                dly_q[i] <= wval;
        for (int i = 0; i < 3; i++)
            if (wr_damp[i])
                damp_q[i] <= wval;
        if (wr_code)
            code_q <= wval;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Access code, status flags, zero point

logic [15:0] entry_d;
assign entry_d = {entry_q[11:0], pwdata[3:0]};
always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        entry_q <= 16'h0000;
        ndig_q <= 3'h0;
        unlocked_q <= 1'b0;
    end
    else if (wr_cmd && pwdata[CMD_LOCK])
    begin
        unlocked_q <= 1'b0;
        ndig_q <= 3'h0;
    end
    else if (wr_digit)
    begin
        entry_q <= entry_d;
        ndig_q <= (ndig_q == 3'h3) ? 3'h0 : ndig_q + 3'h1;
        if (ndig_q == 3'h3)
            unlocked_q <= (entry_d == code_q);
    end
end

logic zero_cmd, zero_fail;
logic [15:0] raw;
assign raw = press_in.value;
assign zero_cmd = wr_cmd & pwdata[CMD_ZERO];
// correction limited to 3 % of span
assign zero_fail = raw > ZERO_MAX;
assign live = (raw > zero_q) ? raw - zero_q : 16'h0000;
always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        zero_q <= 16'h0000;
        zerr_q <= 1'b0;
        clip_q <= 1'b0;
    end
    else
    begin
        if (zero_cmd && !zero_fail)
            zero_q <= raw;
        // Hardware set wins over a write-one clear
        zerr_q <= (zero_cmd & zero_fail) |
            (zerr_q & ~(wr_stat & pwdata[ST_ZERR]));
        clip_q <= (|clip_set) | (clip_q & ~(wr_stat & pwdata[ST_CLIP]));
    end
end

always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        min_q <= MIN_RST;
        max_q <= 16'h0000;
    end
    else if (wr_cmd && pwdata[CMD_MMCLR])
    begin
        min_q <= MIN_RST;
        max_q <= 16'h0000;
    end
    else if (press_in.valid)
    begin
        min_q <= (live < min_q) ? live : min_q;
        max_q <= (live > max_q) ? live : max_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Instrument name

always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        tidx_q <= 5'h00;
        tlen_q <= 6'h00;
    end
    else if (wr_tidx)
        tidx_q <= pwdata[4:0];
    else if (wr_tdat && tch_space && prev_space)
    begin
        tlen_q <= {1'b0, tidx_q - 5'h01};
        tidx_q <= tidx_q - 5'h01;
    end
    else if (wr_tdat)
    begin
        tidx_q <= tidx_q + 5'h01;
        if ({1'b0, tidx_q} >= tlen_q)
            tlen_q <= {1'b0, tidx_q} + 6'h01;
    end
end
// Characters beyond the length read as zero, so no clearing loop
always_ff @(posedge ref_clk)
begin
    if (wr_tdat)
        tag_mem[tidx_q] <= tch;
end

////////////////////////////////////////////////////////////////////////////////
// Damping and switching outputs

logic [2:0][15:0] filt_q;
logic [2:0][3:0] shift;
// Time constant approximated by a power of two of the tick count
function automatic logic [3:0] damp_shift(input logic [15:0] d);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 16; i++)
        if (d[i])
            s = 4'(i + 1);
    return s;
endfunction

generate
    for (gi = 0; gi < 3; gi++)
    begin : g_damp
        logic [16:0] diff;
        assign shift[gi] = damp_shift(damp_q[gi]);
        assign diff = {1'b0, live} - {1'b0, filt_q[gi]};
        // first order filter, zero means direct
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
                filt_q[gi] <= 16'h0000;
            else if (shift[gi] == 4'h0)
                filt_q[gi] <= live;
            else if (tick)
                filt_q[gi] <= filt_q[gi] +
                    16'($signed(diff) >>> shift[gi]);
        end
    end
endgenerate
assign analog_value = filt_q[2];

psol_sw_e sw_q [2];
logic [1:0][15:0] tmr_q;
generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sw
        psol_mode_e mode;
        logic p_on, p_off, want, done;
        logic [15:0] p, sp, rp, lim;
        assign mode = (gi == 0) ? ctrl_q.mode1 : ctrl_q.mode2;
        assign p = filt_q[gi];
        assign sp = thr_q[2 * gi];
        assign rp = thr_q[2 * gi + 1];
        assign p_on = mode[1] ? (p >= rp && p <= sp) : (p >= sp);
        assign p_off = mode[1] ? (p < rp || p > sp) : (p <= rp);
        assign want = (sw_q[gi] == SW_IDLE) ? p_on : p_off;
        assign lim = dly_q[2 * gi + ((sw_q[gi] == SW_ACTIVE) ? 1 : 0)];
        assign done = want && (tmr_q[gi] >= lim);
        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                sw_q[gi] <= SW_IDLE;
                tmr_q[gi] <= 16'h0000;
            end
            else
            begin
                if (!want || done)
                    tmr_q[gi] <= 16'h0000;
                else if (tick)
                    tmr_q[gi] <= tmr_q[gi] + 16'h0001;
                case (sw_q[gi])
                    SW_IDLE: sw_q[gi] <= done ? SW_ACTIVE : SW_IDLE;
                    SW_ACTIVE: sw_q[gi] <= done ? SW_IDLE : SW_ACTIVE;
                    default: sw_q[gi] <= SW_IDLE;
                endcase
            end
        end
        assign switch_out[gi] = (sw_q[gi] == SW_ACTIVE) ^ mode[0];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Indicator

logic [6:0] ref_cnt_q, ref_per;
logic ref_hit;
logic [15:0] sel_val, conv, rnd;
logic [31:0] prod;
logic [3:0] last;
assign ref_per = (ctrl_q.rate == RATE_1) ? REF_P1 :
    (ctrl_q.rate == RATE_2) ? REF_P2 :
    (ctrl_q.rate == RATE_5) ? REF_P5 : REF_P10;
assign ref_hit = tick && (ref_cnt_q >= ref_per - 7'h01);
assign sel_val = (ctrl_q.sel == SEL_LIVE) ? live :
    (ctrl_q.sel == SEL_MIN) ? min_q :
    (ctrl_q.sel == SEL_MAX) ? max_q :
    (ctrl_q.sel == SEL_OFF) ? 16'h0000 :
    thr_q[ctrl_q.sel[1:0]];
assign prod = sel_val * UNIT_SCALE[ctrl_q.unit];
assign conv = prod[27:12];
assign last = 4'(conv % 16'h000A);
assign rnd = conv - 16'(last) + ((last >= 4'h5) ? 16'h000A : 16'h0000);

always_ff @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ref_cnt_q <= 7'h00;
        indicator <= '0;
    end
    else
    begin
        ref_cnt_q <= ref_hit ? 7'h00 : (tick ? ref_cnt_q + 7'h01 : ref_cnt_q);
        indicator.update <= ref_hit;
        indicator.rotate <= ctrl_q.rotate;
        indicator.full_res <= ctrl_q.full_res;
        indicator.unit <= ctrl_q.unit;
        indicator.blank <= (ctrl_q.sel == SEL_OFF);
        if (ref_hit)
            indicator.value <= ctrl_q.full_res ? conv : rnd;
    end
end

endmodule : psol_top
`default_nettype wire

// File: tb/psol_front_end.sv
// Pressure front end model feeding raw samples
`timescale 1ns/1ps
`default_nettype none
module psol_front_end
    import psol_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [15:0] level,
    input wire logic vld_en,
    output psol_press_s press
);
    logic [1:0] div_q = 2'h0;
    logic [15:0] val_q = 16'h0;
    logic vld_q = 1'b0;
    assign press = '{vld_q, val_q};
    // One sample in four is flagged, like a slow converter
    always_ff @(posedge ref_clk)
    begin
        div_q <= div_q + 2'h1;
        val_q <= level;
        vld_q <= vld_en && div_q == 2'h3;
    end
endmodule : psol_front_end
`default_nettype wire

// File: tb/psol_properties.sv
// Bus and indicator checks on the top module ports
`timescale 1ns/1ps
`default_nettype none
module psol_checker
    import psol_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire psol_ind_s indicator
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic done;
    assign done = psel && penable && pready;
    a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("access did not end after one wait state");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (done && paddr > 8'h58 |-> pslverr)
        else $error("unmapped address accepted");
    a_digit_range: assert property (
        done && pwrite && paddr == A_DIGIT && pwdata[3:0] > 4'h9 |-> pslverr)
        else $error("digit above nine accepted");
    a_damp_limit: assert property (
        done && pwrite && paddr == A_DMP1 && pwdata[15:0] > DAMP_MAX |->
        pslverr)
        else $error("damping above limit accepted");
    a_sp_floor: assert property (
        done && pwrite && paddr == A_SP1 && pwdata < 32'h19 |-> pslverr)
        else $error("switch point below floor accepted");
    a_update_pulse: assert property (
        indicator.update |=> !indicator.update)
        else $error("refresh pulse longer than one cycle");
    a_ind_latched: assert property (
        !$stable(indicator.value) |-> indicator.update)
        else $error("indicator changed between refreshes");
    a_cmd_zero: assert property (
        done && !pwrite && paddr == A_CMD |-> prdata == 32'h0)
        else $error("command register read not zero");
endmodule : psol_checker
bind psol_top psol_checker chk_u (.ref_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .indicator);
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the pressure switch logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import psol_pkg::*;
    logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, vld_en = 1;
    logic [15:0] level = 0, analog_value;
    logic [1:0] switch_out;
    psol_press_s press_in;
    psol_ind_s indicator;
    int errors = 0, n_tests = 0;
    always #4 ref_clk = ~ref_clk;
    psol_front_end fe_u (.ref_clk, .level, .vld_en, .press(press_in));
    psol_top #(.TICK_CYCLES(10)) dut_u (.ref_clk, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .press_in,
        .switch_out, .analog_value, .indicator);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk(n < 50, "no ready");
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic er;
        apb(1, a, d, r, er);
        chk(er === e, "write response");
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic er;
        apb(0, a, 0, r, er);
        chk(r === x && er === 1'b0, "read value");
    endtask : rdc
    task automatic lvl(input logic [15:0] p, input int n);
        level <= p;
        cyc(n);
    endtask : lvl
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc(A_CTRL, 32'h100);
        rdc(A_SP1, 32'd10000);
        rdc(A_DMP1, 32'h0);
        rdc(A_DMP3, 32'h0);
        wr(8'h5C, 0, 1);
        wr(A_SP1, 32'h18, 1);
        wr(A_DMP1, 32'h1965, 1);
        $display("reset test done");
    endtask : t_reset
    task automatic t_hyst;
        wr(A_SP1, 32'd5000, 0);
        rdc(A_RP1, 32'd4975);
        wr(A_RP1, 32'd4000, 0);
        wr(A_DS1, 32'd3, 0);
        wr(A_DR1, 32'd2, 0);
        lvl(6000, 15);
        chk(switch_out[0] === 1'b0, "switched early");
        lvl(4500, 20);
        lvl(6000, 15);
        chk(switch_out[0] === 1'b0, "delay not restarted");
        lvl(6000, 30);
        chk(switch_out[0] === 1'b1, "not switched");
        lvl(4500, 50);
        chk(switch_out[0] === 1'b1, "released above release point");
        lvl(3000, 8);
        chk(switch_out[0] === 1'b1, "released early");
        cyc(30);
        chk(switch_out[0] === 1'b0, "not released");
        wr(A_CTRL, 32'h101, 0);
        cyc(3);
        chk(switch_out[0] === 1'b1, "closed polarity");
        wr(A_CTRL, 32'h100, 0);
        $display("hysteresis test done");
    endtask : t_hyst
    task automatic t_modes;
        logic [1:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            wr(A_CTRL, 32'h100 | (32'(m) << 2), 0);
            lvl(m[1] ? 16'd9500 : 16'd10000, 10);
            chk(switch_out[1] === ~m[0], "inside or above");
            lvl(5000, 10);
            chk(switch_out[1] === m[0], "outside or below");
        end
        wr(A_CTRL, 32'h100, 0);
        $display("mode test done");
    endtask : t_modes
    task automatic t_minmax;
        vld_en <= 0;
        lvl(500, 4);
        wr(A_CMD, 32'h2, 0);
        vld_en <= 1;
        lvl(700, 12);
        lvl(300, 12);
        vld_en <= 0;
        cyc(4);
        rdc(A_MIN, 32'd300);
        rdc(A_MAX, 32'd700);
        wr(A_CMD, 32'h2, 0);
        rdc(A_MIN, 32'hFFFF);
        rdc(A_MAX, 32'h0);
        vld_en <= 1;
        $display("min max test done");
    endtask : t_minmax
    task automatic t_zero;
        logic [31:0] r;
        logic er;
        lvl(200, 4);
        wr(A_CMD, 32'h1, 0);
        rdc(A_ZERO, 32'd200);
        lvl(400, 4);
        chk(analog_value === 16'd200, "analog value");
        wr(A_CMD, 32'h1, 0);
        apb(0, A_STAT, 0, r, er);
        chk(r[ST_ZERR] === 1'b1, "zero error flag");
        rdc(A_CMD, 32'h0);
        $display("zero test done");
    endtask : t_zero
    task automatic t_tag;
        wr(A_TIDX, 0, 0);
        wr(A_TDAT, 32'h41, 0);
        wr(A_TDAT, 32'h2D, 0);
        wr(A_TDAT, 32'h20, 0);
        wr(A_TDAT, 32'h20, 0);
        rdc(A_TLEN, 32'd2);
        wr(A_TDAT, 32'h23, 1);
        $display("tag test done");
    endtask : t_tag
    task automatic t_refresh;
        int n;
        lvl(16'd407, 4);
        for (int i = 0; i < 2; i++)
        begin
            wr(A_CTRL, i ? 32'h580 : 32'h200, 0);
            n = 0;
            while (indicator.update !== 1'b1 && n < 1200)
            begin
                cyc(1);
                n++;
            end
            n = 0;
            do
            begin
                cyc(1);
                n++;
            end
            while (indicator.update !== 1'b1 && n < 1200);
            chk(n == (i ? 100 : 1000), "refresh period");
            chk(indicator.value === (i ? 16'd210 : 16'd207) &&
                indicator.rotate === i[0], "indicator");
        end
        wr(A_CTRL, 32'h100, 0);
        $display("refresh test done");
    endtask : t_refresh
    task automatic t_code;
        wr(A_CODE, 32'h1234, 0);
        wr(A_CTRL, 32'h100, 1);
        wr(A_DIGIT, 32'hA, 1);
        for (int d = 1; d < 5; d++)
            wr(A_DIGIT, d, 0);
        wr(A_CTRL, 32'h100, 0);
        $display("access code test done");
    endtask : t_code
    ////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial
    begin
        cyc(5);
        resetn <= 1;
        cyc(3);
        t_reset;
        t_hyst;
        t_modes;
        t_minmax;
        t_zero;
        t_tag;
        t_refresh;
        t_code;
        test_done;
    end
    initial
    begin
        cyc(20000);
        errors++;
        test_done;
    end
endmodule : testbench
`default_nettype wire
